// ==== logic/lrsi_regs.svh ====
`ifndef LRSI_REGS_SVH
`define LRSI_REGS_SVH

// ----------------------------------------------------------------
// bus widths and port selection
// ----------------------------------------------------------------
`define LRSI_ADDR_W        12
`define LRSI_DATA_W        16
`define LRSI_NUM_PORTS     4

// ----------------------------------------------------------------
// per-port register offsets (low address byte)
// ----------------------------------------------------------------
`define LRSI_OFS_CTRL      8'h90
`define LRSI_OFS_LIVE      8'h94
`define LRSI_OFS_LATCH     8'h96
`define LRSI_OFS_IRQEN     8'h98
`define LRSI_OFS_VCNT      8'h9c
`define LRSI_OFS_XCNT      8'h9e

// ----------------------------------------------------------------
// global interrupt enable register, full address
// ----------------------------------------------------------------
`define LRSI_ADDR_GLOBAL   12'h0fe
`define LRSI_GIE_LSB       1

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LRSI_CTRL_ZSOFF    0
`define LRSI_CTRL_E3SEL    3
`define LRSI_LIVE_LOS      0
`define LRSI_LIVE_VNZ      1
`define LRSI_LIVE_XNZ      3
`define LRSI_EV_LOSCHG     0
`define LRSI_EV_VNZ        1
`define LRSI_EV_VIOL       2
`define LRSI_EV_XNZ        3
`define LRSI_EV_XZ         4
`define LRSI_EV_CWD        5
`define LRSI_EV_W          6

// ----------------------------------------------------------------
// reset values and counter saturation value
// ----------------------------------------------------------------
`define LRSI_RST_CTRL      2'h0
`define LRSI_RST_EV        6'h00
`define LRSI_RST_GIE       4'h0
`define LRSI_RST_WORD      16'h0000
`define LRSI_CNT_MAX       16'hffff

`endif

// ==== logic/lrsi_pkg.sv ====
`include "lrsi_regs.svh"

package lrsi_pkg;

    typedef logic [`LRSI_ADDR_W-1:0] lrsi_addr_t;
    typedef logic [`LRSI_DATA_W-1:0] lrsi_word_t;
    typedef logic [`LRSI_EV_W-1:0]   lrsi_ev_t;

    // per-port decoder signals, all on CORE_CLK
    typedef struct packed {
        logic line_hdb3;
        logic los_detect;
        logic codeword;
        logic excess_zero;
        logic bipolar_viol;
        logic line_code_violation;
    } lrsi_dec_t;

endpackage : lrsi_pkg

// ==== logic/lrsi_err_cnt.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lrsi_regs.svh"

module lrsi_err_cnt
    import lrsi_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // count control
    input  wire logic              inc,
    input  wire logic              rd_clr,
    // state
    output lrsi_pkg::lrsi_word_t   count,
    output logic                   nonzero
);

    lrsi_word_t cnt_ff;
    lrsi_word_t nxt_cnt;
    lrsi_word_t base;

    // ----------------------------------------------------------------
    // saturating count, cleared by read; an event in the clear cycle
    // is kept so no error goes unseen
    // ----------------------------------------------------------------
    assign base    = rd_clr ? `LRSI_RST_WORD : cnt_ff;
    assign nxt_cnt = (inc && (base != `LRSI_CNT_MAX)) ? base + 16'h0001 : base;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            cnt_ff <= `LRSI_RST_WORD;
        else
            cnt_ff <= nxt_cnt;
    end

    assign count   = cnt_ff;
    assign nonzero = (cnt_ff != `LRSI_RST_WORD);

endmodule // lrsi_err_cnt

`default_nettype wire

// ==== logic/lrsi_top.sv ====
// Behaviour
// RL1 - live status bit 0 shows loss of signal
// RL2 - decoding off forces loss of signal cleared
// RL3 - bit 5 latches codeword detection
// RL4 - bit 4 latches excessive zero event
// RL5 - bit 3 latches zero-count nonzero rise
// RL6 - bit 2 latches violation or E3 violation
// RL7 - bit 1 latches violation-count nonzero rise
// RL8 - bit 0 latches any loss-of-signal change
// RL9 - enable plus port global enable gate interrupt
// RL10 - enable bits: one enables, reset zero
// RL11 - per-port copies, port picks high digit
// RL12 - live count bits show counter nonzero
// RL13 - control bit disables zero-suppression decoding
// RL14 - control bit selects E3 counting, not B3ZS
// RL15 - latched bits clear by writing one, set wins
// RL16 - port interrupt is OR of enabled latches
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "lrsi_regs.svh"

module lrsi_top
    import lrsi_pkg::*;
(
    // clock and reset
    input  wire logic                                       CORE_CLK,
    input  wire logic                                       RST_N,
    // register port
    input  wire lrsi_pkg::lrsi_addr_t                       REG_ADDR,
    input  wire lrsi_pkg::lrsi_word_t                       REG_WDATA,
    input  wire logic                                       REG_WR,
    input  wire logic                                       REG_RD,
    output lrsi_pkg::lrsi_word_t                            REG_RDATA,
    // line decoder signals, one per port
    input  wire lrsi_pkg::lrsi_dec_t [`LRSI_NUM_PORTS-1:0]  DEC_IN,
    // status and interrupts
    output logic [`LRSI_NUM_PORTS-1:0]                      SIGNAL_LOST,
    output logic [`LRSI_NUM_PORTS-1:0]                      PORT_IRQ,
    output logic                                            IRQ
);

    import lrsi_pkg::*;

    // ----------------------------------------------------------------
    // address decode helper
    // ----------------------------------------------------------------
    // port n lives at high digit 2n; odd digits and digits above 6 are empty
    function automatic logic port_hit(input lrsi_addr_t addr,
                                      input logic [1:0] port,
                                      input logic [7:0] ofs);
        port_hit = (addr[11] == 1'b0) && (addr[10:9] == port) &&
                   (addr[8] == 1'b0) && (addr[7:0] == ofs);
    endfunction

    // ----------------------------------------------------------------
    // global port interrupt enable
    // ----------------------------------------------------------------
    logic [`LRSI_NUM_PORTS-1:0] port_status_irq_en_ff;
    logic [`LRSI_NUM_PORTS-1:0] nxt_port_status_irq_en;
    logic                       global_hit;

    assign global_hit = (REG_ADDR == `LRSI_ADDR_GLOBAL);
    assign nxt_port_status_irq_en = (REG_WR && global_hit) ?
        REG_WDATA[`LRSI_GIE_LSB +: `LRSI_NUM_PORTS] : port_status_irq_en_ff;

    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
            port_status_irq_en_ff <= `LRSI_RST_GIE;
        else
            port_status_irq_en_ff <= nxt_port_status_irq_en;
    end

    // ----------------------------------------------------------------
    // per-port state
    // ----------------------------------------------------------------
    logic [1:0]   ctrl_ff   [`LRSI_NUM_PORTS];
    logic         los_ff    [`LRSI_NUM_PORTS];
    logic         vnz_ff    [`LRSI_NUM_PORTS];
    logic         xnz_ff    [`LRSI_NUM_PORTS];
    lrsi_ev_t     latch_ff  [`LRSI_NUM_PORTS];
    lrsi_ev_t     irqen_ff  [`LRSI_NUM_PORTS];
    lrsi_word_t   vcnt      [`LRSI_NUM_PORTS];
    lrsi_word_t   xcnt      [`LRSI_NUM_PORTS];
    logic         vnz       [`LRSI_NUM_PORTS];
    logic         xnz       [`LRSI_NUM_PORTS];
    lrsi_word_t   port_rd   [`LRSI_NUM_PORTS];
    logic         port_sel  [`LRSI_NUM_PORTS];
    logic [`LRSI_NUM_PORTS-1:0] nxt_port_irq;
    logic [`LRSI_NUM_PORTS-1:0] nxt_los_vec;

    genvar p;
    generate
        for (p = 0; p < `LRSI_NUM_PORTS; p = p + 1)
        begin : g_port
            logic       hit_ctrl;
            logic       hit_live;
            logic       hit_latch;
            logic       hit_irqen;
            logic       hit_vcnt;
            logic       hit_xcnt;
            logic       zs_off;
            logic       e3_sel_eff;
            logic       nxt_los;
            logic       viol_ev;
            logic [1:0] nxt_ctrl;
            lrsi_ev_t   events;
            lrsi_ev_t   clr_mask;
            lrsi_ev_t   nxt_latch;
            lrsi_ev_t   nxt_irqen;
            lrsi_word_t live_word;

            // --------------------------------------------------------
            // decode
            // --------------------------------------------------------
            assign hit_ctrl  = port_hit(REG_ADDR, 2'(p), `LRSI_OFS_CTRL);   // RL11
            assign hit_live  = port_hit(REG_ADDR, 2'(p), `LRSI_OFS_LIVE);   // RL11
            assign hit_latch = port_hit(REG_ADDR, 2'(p), `LRSI_OFS_LATCH);  // RL11
            assign hit_irqen = port_hit(REG_ADDR, 2'(p), `LRSI_OFS_IRQEN);  // RL11
            assign hit_vcnt  = port_hit(REG_ADDR, 2'(p), `LRSI_OFS_VCNT);   // RL11
            assign hit_xcnt  = port_hit(REG_ADDR, 2'(p), `LRSI_OFS_XCNT);   // RL11

            // --------------------------------------------------------
            // control
            // --------------------------------------------------------
            assign nxt_ctrl = (REG_WR && hit_ctrl) ?
                {REG_WDATA[`LRSI_CTRL_E3SEL], REG_WDATA[`LRSI_CTRL_ZSOFF]} : ctrl_ff[p];
            assign zs_off     = ctrl_ff[p][0];                                   // RL13
            // the e3 selection means nothing on a b3zs line
            assign e3_sel_eff = ctrl_ff[p][1] && DEC_IN[p].line_hdb3;            // RL14

            // --------------------------------------------------------
            // live status
            // --------------------------------------------------------
            assign nxt_los = DEC_IN[p].los_detect && !zs_off;                    // RL2
            assign viol_ev = e3_sel_eff ? DEC_IN[p].line_code_violation
                                        : DEC_IN[p].bipolar_viol;                // RL14

            lrsi_err_cnt u_vcnt
            (
                .clk     (CORE_CLK),
                .rst_n   (RST_N),
                .inc     (viol_ev),
                .rd_clr  (REG_RD && hit_vcnt),
                .count   (vcnt[p]),
                .nonzero (vnz[p])
            );

            lrsi_err_cnt u_xcnt
            (
                .clk     (CORE_CLK),
                .rst_n   (RST_N),
                .inc     (DEC_IN[p].excess_zero),
                .rd_clr  (REG_RD && hit_xcnt),
                .count   (xcnt[p]),
                .nonzero (xnz[p])
            );

            // --------------------------------------------------------
            // latched events
            // --------------------------------------------------------
            assign events[`LRSI_EV_CWD]    = DEC_IN[p].codeword;                 // RL3
            assign events[`LRSI_EV_XZ]     = DEC_IN[p].excess_zero;              // RL4
            assign events[`LRSI_EV_XNZ]    = xnz[p] && !xnz_ff[p];               // RL5
            assign events[`LRSI_EV_VIOL]   = viol_ev;                            // RL6
            assign events[`LRSI_EV_VNZ]    = vnz[p] && !vnz_ff[p];               // RL7
            assign events[`LRSI_EV_LOSCHG] = nxt_los != los_ff[p];               // RL8

            assign clr_mask  = (REG_WR && hit_latch) ? REG_WDATA[`LRSI_EV_W-1:0]
                                                     : `LRSI_RST_EV;
            // a fresh event beats a clear in the same cycle
            assign nxt_latch = (latch_ff[p] & ~clr_mask) | events;               // RL15
            assign nxt_irqen = (REG_WR && hit_irqen) ? REG_WDATA[`LRSI_EV_W-1:0]
                                                     : irqen_ff[p];              // RL10
            assign nxt_port_irq[p] = (|(nxt_latch & irqen_ff[p]))
                                     && port_status_irq_en_ff[p];                // RL9 RL16
            assign nxt_los_vec[p]  = nxt_los;

            always_ff @(posedge CORE_CLK)
            begin
                if (!RST_N)
                begin
                    ctrl_ff[p]  <= `LRSI_RST_CTRL;
                    los_ff[p]   <= 1'b0;
                    vnz_ff[p]   <= 1'b0;
                    xnz_ff[p]   <= 1'b0;
                    latch_ff[p] <= `LRSI_RST_EV;
                    irqen_ff[p] <= `LRSI_RST_EV;                                 // RL10
                end
                else
                begin
                    ctrl_ff[p]  <= nxt_ctrl;
                    los_ff[p]   <= nxt_los;
                    vnz_ff[p]   <= vnz[p];
                    xnz_ff[p]   <= xnz[p];
                    latch_ff[p] <= nxt_latch;
                    irqen_ff[p] <= nxt_irqen;
                end
            end

            // --------------------------------------------------------
            // read selection
            // --------------------------------------------------------
            always_comb
            begin
                live_word = `LRSI_RST_WORD;
                live_word[`LRSI_LIVE_LOS] = los_ff[p];                           // RL1
                live_word[`LRSI_LIVE_VNZ] = vnz[p];                              // RL12
                live_word[`LRSI_LIVE_XNZ] = xnz[p];                              // RL12
            end

            assign port_sel[p] = hit_ctrl | hit_live | hit_latch |
                                 hit_irqen | hit_vcnt | hit_xcnt;
            assign port_rd[p] =
                hit_ctrl  ? {12'h000, ctrl_ff[p][1], 2'b00, ctrl_ff[p][0]} :
                hit_live  ? live_word :
                hit_latch ? {10'h000, latch_ff[p]} :
                hit_irqen ? {10'h000, irqen_ff[p]} :
                hit_vcnt  ? vcnt[p] :
                hit_xcnt  ? xcnt[p] : `LRSI_RST_WORD;
        end
    endgenerate

    // ----------------------------------------------------------------
    // read data merge, one cycle after the strobe
    // ----------------------------------------------------------------
    lrsi_word_t rd_mux;
    lrsi_word_t rdata_ff;
    lrsi_word_t nxt_rdata;

    always_comb
    begin
        rd_mux = `LRSI_RST_WORD;
        for (int i = 0; i < `LRSI_NUM_PORTS; i++)
        begin
            if (port_sel[i])
                rd_mux = port_rd[i];
        end
        if (global_hit)
            rd_mux = {11'h000, port_status_irq_en_ff, 1'b0};
    end

    // unmapped addresses read zero; data only stand in the cycle after
    assign nxt_rdata = REG_RD ? rd_mux : `LRSI_RST_WORD;

    // ----------------------------------------------------------------
    // output flops
    // ----------------------------------------------------------------
    logic [`LRSI_NUM_PORTS-1:0] port_irq_ff;
    logic [`LRSI_NUM_PORTS-1:0] los_out_ff;
    logic                       irq_ff;

    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            rdata_ff    <= `LRSI_RST_WORD;
            port_irq_ff <= '0;
            los_out_ff  <= '0;
            irq_ff      <= 1'b0;
        end
        else
        begin
            rdata_ff    <= nxt_rdata;
            port_irq_ff <= nxt_port_irq;                                         // RL16
            los_out_ff  <= nxt_los_vec;
            irq_ff      <= |nxt_port_irq;
        end
    end

    assign REG_RDATA   = rdata_ff;
    assign PORT_IRQ    = port_irq_ff;
    assign SIGNAL_LOST = los_out_ff;
    assign IRQ         = irq_ff;

endmodule // lrsi_top

`default_nettype wire

// ==== verification/lrsi_dec_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// line decoder stand-in, one lane per port
// ----------------------------------------
module lrsi_dec_model
    import lrsi_pkg::*;
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // request from the bench
    input  wire logic                  go,
    input  wire logic [1:0]            port,
    input  wire logic [5:0]            val,
    // decoder side
    output lrsi_pkg::lrsi_dec_t [3:0]  dec
);

    // levels hold until the next request, event pulses last one cycle only
    always @(posedge clk)
    begin
        for (int i = 0; i < 4; i++)
            dec[i][3:0] <= 4'h0;
        if (!rst_n)
            dec <= 24'h000000;
        else if (go)
            dec[port] <= val;
    end
endmodule // lrsi_dec_model

`default_nettype wire

// ==== verification/lrsi_chk_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lrsi_regs.svh"

module lrsi_chk
    import lrsi_pkg::*;
(
    // clock and reset
    input  wire logic                      CORE_CLK,
    input  wire logic                      RST_N,
    // register port
    input  wire lrsi_pkg::lrsi_addr_t      REG_ADDR,
    input  wire lrsi_pkg::lrsi_word_t      REG_WDATA,
    input  wire logic                      REG_WR,
    input  wire logic                      REG_RD,
    input  wire lrsi_pkg::lrsi_word_t      REG_RDATA,
    // decoder and status
    input  wire lrsi_pkg::lrsi_dec_t [3:0] DEC_IN,
    input  wire logic [3:0]                SIGNAL_LOST,
    input  wire logic [3:0]                PORT_IRQ,
    input  wire logic                      IRQ
);
    logic [3:0] gie_ff, cw_ff, xz_ff, lc_ff, zs_ff, los_v;
    wire logic  is_latch = REG_ADDR[7:0] == `LRSI_OFS_LATCH && !REG_ADDR[11] && !REG_ADDR[8];
    wire logic  is_ctrl  = REG_ADDR[7:0] == `LRSI_OFS_CTRL && !REG_ADDR[11] && !REG_ADDR[8];
    wire logic [1:0] prt = REG_ADDR[10:9];

    // write-one-to-clear of latch bit b on port i
    function automatic logic w1c(input int i, input int b);
        return REG_WR && is_latch && REG_ADDR[10:9] == 2'(i) && REG_WDATA[b];
    endfunction

    // mirrors of the global enable, decode-off and three sticky bits; set beats clear
    always_ff @(posedge CORE_CLK)
    begin
        for (int i = 0; i < 4; i++)
        begin
            los_v[i] <= DEC_IN[i].los_detect;
            cw_ff[i] <= RST_N && (DEC_IN[i].codeword || (cw_ff[i] && !w1c(i, 5)));
            xz_ff[i] <= RST_N && (DEC_IN[i].excess_zero || (xz_ff[i] && !w1c(i, 4)));
            lc_ff[i] <= RST_N && (((DEC_IN[i].los_detect && !zs_ff[i]) != SIGNAL_LOST[i])
                                  || (lc_ff[i] && !w1c(i, 0)));
            if (!RST_N)
                zs_ff[i] <= 1'b0;
            else if (REG_WR && is_ctrl && REG_ADDR[10:9] == 2'(i))
                zs_ff[i] <= REG_WDATA[0];
        end
        if (!RST_N)
            gie_ff <= 4'h0;
        else if (REG_WR && REG_ADDR == `LRSI_ADDR_GLOBAL)
            gie_ff <= REG_WDATA[4:1];
    end

    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    sequence latch_rd_s;
        REG_RD && is_latch;
    endsequence

    // a rewrite in the next cycle could legally re-enable, so require none
    sequence gie_off_s;
        REG_WR && REG_ADDR == `LRSI_ADDR_GLOBAL && REG_WDATA[4:1] == 4'h0
        ##1 !(REG_WR && REG_ADDR == `LRSI_ADDR_GLOBAL);
    endsequence

    rdata_idle_a: assert property (REG_RDATA != 16'h0000 |-> $past(REG_RD))
        else $error("read data outside its answer cycle");
    irq_or_a: assert property (IRQ == |PORT_IRQ)
        else $error("irq is not the or of port irqs");
    irq_gate_a: assert property ((PORT_IRQ & ~(gie_ff | $past(gie_ff))) == 4'h0)
        else $error("port irq without global enable");
    gie_off_a: assert property (gie_off_s |=> PORT_IRQ == 4'h0)
        else $error("port irq stays after global disable");
    los_gate_a: assert property (SIGNAL_LOST == (los_v & ~$past(zs_ff)))
        else $error("signal lost disagrees with detector and decode-off");
    cw_latch_a: assert property (latch_rd_s |=> REG_RDATA[5] == $past(cw_ff[prt]))
        else $error("codeword latch bit wrong");
    xz_latch_a: assert property (latch_rd_s |=> REG_RDATA[4] == $past(xz_ff[prt]))
        else $error("excess zero latch bit wrong");
    los_latch_a: assert property (latch_rd_s |=> REG_RDATA[0] == $past(lc_ff[prt]))
        else $error("signal lost change latch bit wrong");
endmodule // lrsi_chk

bind lrsi_top lrsi_chk u_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .DEC_IN(DEC_IN), .SIGNAL_LOST(SIGNAL_LOST), .PORT_IRQ(PORT_IRQ), .IRQ(IRQ));

`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lrsi_regs.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end

module tb_top;
    import lrsi_pkg::*;

    logic             CORE_CLK  = 1'b0;
    logic             RST_N     = 1'b0;
    logic             REG_WR    = 1'b0;
    logic             REG_RD    = 1'b0;
    lrsi_addr_t       REG_ADDR  = 12'h000;
    lrsi_word_t       REG_WDATA = 16'h0000;
    lrsi_word_t       REG_RDATA;
    lrsi_dec_t [3:0]  DEC_IN;
    logic [3:0]       SIGNAL_LOST;
    logic [3:0]       PORT_IRQ;
    logic             IRQ;
    logic             go    = 1'b0;
    logic             rd_q  = 1'b0;
    logic [1:0]       dport = 2'h0;
    logic [5:0]       dval  = 6'h00;
    logic [1:0]       k;
    logic [31:0]      rs    = 32'h7b32;
    lrsi_word_t       ev;
    lrsi_word_t       exp_q[$];
    int               num_errors = 0;
    int               cmp_count  = 0;
    int               cyc        = 0;

    lrsi_top u_lrsi_top (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .DEC_IN(DEC_IN), .SIGNAL_LOST(SIGNAL_LOST), .PORT_IRQ(PORT_IRQ), .IRQ(IRQ));
    lrsi_dec_model u_lrsi_dec_model (.clk(CORE_CLK), .rst_n(RST_N), .go(go), .port(dport),
        .val(dval), .dec(DEC_IN));

    always #12.5 CORE_CLK = ~CORE_CLK;

    function automatic logic [31:0] nxt(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    function automatic lrsi_addr_t ad(input logic [1:0] p, input logic [7:0] o);
        return {1'b0, p, 1'b0, o};
    endfunction

    // ----------------------------------------
    // bus and decoder tasks
    // ----------------------------------------
    task automatic wr(input lrsi_addr_t a, input lrsi_word_t d);
        @(posedge CORE_CLK);
        REG_ADDR  <= a;
        REG_WDATA <= d;
        REG_WR    <= 1'b1;
        @(posedge CORE_CLK);
        REG_WR    <= 1'b0;
    endtask

    task automatic rd(input lrsi_addr_t a, input lrsi_word_t e);
        exp_q.push_back(e);
        @(posedge CORE_CLK);
        REG_ADDR <= a;
        REG_RD   <= 1'b1;
        @(posedge CORE_CLK);
        REG_RD   <= 1'b0;
    endtask

    // waits past the counter-nonzero latch, which trails the event by a cycle
    task automatic fire(input logic [1:0] p, input logic [5:0] v);
        @(posedge CORE_CLK);
        dport <= p;
        dval  <= v;
        go    <= 1'b1;
        @(posedge CORE_CLK);
        go    <= 1'b0;
        repeat (3) @(posedge CORE_CLK);
    endtask

    task automatic test_done;
        if (num_errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ----------------------------------------
    // read answer monitor and timeout
    // ----------------------------------------
    always @(posedge CORE_CLK)
    begin
        rd_q <= REG_RD;
        if (rd_q)
        begin
            ev = exp_q.pop_front();
            `CHK("read data", ev, REG_RDATA)
        end
        cyc++;
        if (cyc > 2000)
        begin
            num_errors++;
            test_done();
        end
    end

    initial
    begin
        repeat (2) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        for (int p = 0; p < 4; p++)
        begin
            rd(ad(p[1:0], `LRSI_OFS_LATCH), 16'h0000);
            rd(ad(p[1:0], `LRSI_OFS_IRQEN), 16'h0000);
            rs = nxt(rs);
            wr(ad(p[1:0], `LRSI_OFS_IRQEN), rs[15:0]);
            rd(ad(p[1:0], `LRSI_OFS_IRQEN), {10'h000, rs[5:0]});
        end
        rd(ad(2'h0, 8'h92), 16'h0000);
        k = rs[17:16];
        wr(ad(k, `LRSI_OFS_IRQEN), 16'h0000);
        fire(k, 6'h0e);
        rd(ad(k, `LRSI_OFS_LIVE), 16'h000a);
        rd(ad(k, `LRSI_OFS_LATCH), 16'h003e);
        rd(ad(k ^ 2'h1, `LRSI_OFS_LATCH), 16'h0000);
        wr(ad(k, `LRSI_OFS_LATCH), 16'h0014);
        rd(ad(k, `LRSI_OFS_LATCH), 16'h002a);
        rd(ad(k, `LRSI_OFS_VCNT), 16'h0001);
        rd(ad(k, `LRSI_OFS_LIVE), 16'h0008);
        wr(ad(k, `LRSI_OFS_LATCH), 16'h003f);
        rd(ad(k, `LRSI_OFS_LATCH), 16'h0000);
        wr(ad(k, `LRSI_OFS_IRQEN), 16'h0020);
        fire(k, 6'h08);
        `CHK("port irq", 4'h0, PORT_IRQ)
        wr(`LRSI_ADDR_GLOBAL, 16'h0002 << k);
        repeat (2) @(posedge CORE_CLK);
        `CHK("port irq", 4'h1 << k, PORT_IRQ)
        `CHK("irq", 1'b1, IRQ)
        wr(`LRSI_ADDR_GLOBAL, 16'h0000);
        repeat (2) @(posedge CORE_CLK);
        `CHK("irq", 1'b0, IRQ)
        wr(`LRSI_ADDR_GLOBAL, 16'h0002 << k);
        rd(`LRSI_ADDR_GLOBAL, 16'h0002 << k);
        wr(ad(k, `LRSI_OFS_LATCH), 16'h0020);
        repeat (2) @(posedge CORE_CLK);
        `CHK("port irq", 4'h0, PORT_IRQ)
        fire(k, 6'h10);
        `CHK("signal lost", 4'h1 << k, SIGNAL_LOST)
        rd(ad(k, `LRSI_OFS_LIVE), 16'h0009);
        rd(ad(k, `LRSI_OFS_LATCH), 16'h0001);
        wr(ad(k, `LRSI_OFS_LATCH), 16'h0001);
        wr(ad(k, `LRSI_OFS_CTRL), 16'h0001);
        repeat (2) @(posedge CORE_CLK);
        `CHK("signal lost", 4'h0, SIGNAL_LOST)
        rd(ad(k, `LRSI_OFS_LATCH), 16'h0001);
        rd(ad(k, `LRSI_OFS_CTRL), 16'h0001);
        fire(k, 6'h00);
        wr(ad(k, `LRSI_OFS_LATCH), 16'h003f);
        for (int i = 0; i < 3; i++)
        begin
            wr(ad(k, `LRSI_OFS_CTRL), {12'h000, i != 0, 3'h0});
            fire(k, {i != 1, 5'h01});
            rd(ad(k, `LRSI_OFS_LATCH), (i == 2) ? 16'h0006 : 16'h0000);
            rd(ad(k, `LRSI_OFS_VCNT), (i == 2) ? 16'h0001 : 16'h0000);
            wr(ad(k, `LRSI_OFS_LATCH), 16'h003f);
        end
        rd(ad(k, `LRSI_OFS_XCNT), 16'h0001);
        rd(ad(k, `LRSI_OFS_LIVE), 16'h0000);
        repeat (3) @(posedge CORE_CLK);
        test_done();
    end
endmodule // tb_top

`default_nettype wire
